// ==== hdl/psc_pkg.sv ====
// How it works
// - Summary byte bits 7..0: busy, off, out OV, out OC, in UV, temp, comm, other.
// - Word high byte: vout, iout, input, vendor, power-not-good, fan, other, unknown.
// - Status word reads two bytes; low byte equals the summary byte.
// - Fan status: fan faults at bits 7 and 6, speed overrides at 3 and 2.
// - After power-up the output is on while the remote pin is high.
// - On/off command data 0x80 turns output on, 0x00 turns it off.
// - Off for two seconds then on clears all alarms and shutdowns.
// - Clear-faults empties every status register and releases the alert line.
// - A fault still present after clear-faults sets its bits and alert again.
// - Lock byte 0x00 allows all, 0x80 only itself and clear-faults, 0x40 itself, clear-faults and on/off.
// - Reads of every supported command succeed whatever the lock setting.
// - Lock byte resets to 0x80 and can be saved by store-defaults.
// - A setpoint write makes the unit ignore the programming pin from then on.
// - After controller restart the programming pin sets the voltage again.
// - Overcurrent and overtemperature responses default hiccup, may be latched.
// - Latched unit restarts after being held off two seconds or power cycled.
// - Input undervoltage warning flag rises before the low-input shutdown.
// - Maker identity read returns at most five ASCII characters.
// - Model identity read returns sixteen bytes.
package psc_pkg;
	localparam logic [7:0] CMD_ON_OFF   = 8'h01;
	localparam logic [7:0] CMD_CLEAR    = 8'h03;
	localparam logic [7:0] CMD_LOCK     = 8'h10;
	localparam logic [7:0] CMD_STORE    = 8'h11;
	localparam logic [7:0] CMD_VSET     = 8'h21;
	localparam logic [7:0] CMD_OC_RESP  = 8'h47;
	localparam logic [7:0] CMD_OT_RESP  = 8'h50;
	localparam logic [7:0] CMD_SBYTE    = 8'h78;
	localparam logic [7:0] CMD_SWORD    = 8'h79;
	localparam logic [7:0] CMD_S_VOUT   = 8'h7a;
	localparam logic [7:0] CMD_S_IOUT   = 8'h7b;
	localparam logic [7:0] CMD_S_INPUT  = 8'h7c;
	localparam logic [7:0] CMD_S_TEMP   = 8'h7d;
	localparam logic [7:0] CMD_S_VENDOR = 8'h80;
	localparam logic [7:0] CMD_S_FAN    = 8'h81;
	localparam logic [7:0] CMD_MAKER    = 8'h99;
	localparam logic [7:0] CMD_MODEL    = 8'h9a;

	localparam logic [7:0] OUT_ON       = 8'h80;
	localparam logic [7:0] OUT_OFF      = 8'h00;
	localparam logic [7:0] LOCK_NONE    = 8'h00;
	localparam logic [7:0] LOCK_ALL     = 8'h80;
	localparam logic [7:0] LOCK_OPER    = 8'h40;
	localparam logic [7:0] RESP_HICCUP  = 8'hc8;
	localparam logic [7:0] RESP_LATCH   = 8'hc0;
	localparam logic [15:0] VSET_RESET  = 16'h0000;

	// Live condition inputs, one bit each.
	localparam int F_VOV_F  = 0;
	localparam int F_VOV_W  = 1;
	localparam int F_VUV_W  = 2;
	localparam int F_VUV_F  = 3;
	localparam int F_IOC_F  = 4;
	localparam int F_IOC_W  = 5;
	localparam int F_IOV_F  = 6;
	localparam int F_IOV_W  = 7;
	localparam int F_IUV_W  = 8;
	localparam int F_IUV_F  = 9;
	localparam int F_OT_F   = 10;
	localparam int F_OT_W   = 11;
	localparam int F_FAN1_F = 12;
	localparam int F_FAN2_F = 13;
	localparam int F_FAN1_O = 14;
	localparam int F_FAN2_O = 15;
	localparam int F_RAIL_F = 16;
	localparam int F_OTHER  = 17;
	localparam int FLT_W    = 18;

	localparam int RLEN_W   = 5;
	localparam logic [RLEN_W-1:0] LEN_NONE  = 5'h00;
	localparam logic [RLEN_W-1:0] LEN_BYTE  = 5'h01;
	localparam logic [RLEN_W-1:0] LEN_WORD  = 5'h02;
	localparam logic [RLEN_W-1:0] LEN_MAKER = 5'h05;
	localparam logic [RLEN_W-1:0] LEN_MODEL = 5'h10;

	localparam longint CLK_HZ      = 20000000;
	localparam longint OFF_HOLD_MS = 2000;
	localparam longint OFF_HOLD_CYC = OFF_HOLD_MS * (CLK_HZ / 1000);
endpackage : psc_pkg

// ==== hdl/psc_regs.sv ====
`timescale 1ns/100ps

module psc_link
	import psc_pkg::*;
(
	// Link side
	input  wire logic          link_clk,
	input  wire logic          arst_n,
	input  wire logic          lk_req,
	input  wire logic          lk_wr,
	input  wire logic [7:0]    lk_cmd,
	input  wire logic [15:0]   lk_wdata,
	output logic               lk_busy,
	output logic               lk_done,
	output logic [127:0]       lk_rdata,
	output logic [RLEN_W-1:0]  lk_rlen,
	// Crossing to the core domain
	output logic               x_req_tog,
	output logic               x_wr,
	output logic [7:0]         x_cmd,
	output logic [15:0]        x_wdata,
	input  wire logic          x_ack_tog,
	input  wire logic [127:0]  x_rdata,
	input  wire logic [RLEN_W-1:0] x_rlen
);
	typedef struct packed {
		logic              busy;
		logic              done;
		logic              req_tog;
		logic              wr;
		logic [7:0]        cmd;
		logic [15:0]       wdata;
		logic              a1;
		logic              a2;
		logic              a3;
		logic [127:0]      rdata;
		logic [RLEN_W-1:0] rlen;
	} psc_link_t;

	psc_link_t q_r;
	psc_link_t q_nxt;

	always_comb begin
		q_nxt = q_r;
		q_nxt.done = 1'b0;
		q_nxt.a1 = x_ack_tog;
		q_nxt.a2 = q_r.a1;
		q_nxt.a3 = q_r.a2;
		// A request made while one is in flight is dropped.
		if (lk_req && !q_r.busy) begin
			q_nxt.busy = 1'b1;
			q_nxt.req_tog = !q_r.req_tog;
			q_nxt.wr = lk_wr;
			q_nxt.cmd = lk_cmd;
			q_nxt.wdata = lk_wdata;
		end
		// Answer words are stable once the acknowledge toggle is seen.
		if (q_r.busy && (q_r.a2 != q_r.a3)) begin
			q_nxt.busy = 1'b0;
			q_nxt.done = 1'b1;
			q_nxt.rdata = x_rdata;
			q_nxt.rlen = x_rlen;
		end
	end

	always_ff @(posedge link_clk or negedge arst_n) begin
		if (!arst_n) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign lk_busy   = q_r.busy;
	assign lk_done   = q_r.done;
	assign lk_rdata  = q_r.rdata;
	assign lk_rlen   = q_r.rlen;
	assign x_req_tog = q_r.req_tog;
	assign x_wr      = q_r.wr;
	assign x_cmd     = q_r.cmd;
	assign x_wdata   = q_r.wdata;
endmodule : psc_link

module psc_regs
	import psc_pkg::*;
#(
	parameter longint        OFF_HOLD = OFF_HOLD_CYC,
	parameter int            CNT_W    = 26,
	// Identity strings; values are arbitrary.
	parameter logic [39:0]   MAKER_ID = 40'h4d414b4552,
	parameter logic [127:0]  MODEL_ID = 128'h4d4f44454c2d30303030303030303030
)
(
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               arst_n,
	// Link side
	input  wire logic               link_clk,
	input  wire logic               lk_req,
	input  wire logic               lk_wr,
	input  wire logic [7:0]         lk_cmd,
	input  wire logic [15:0]        lk_wdata,
	output logic                    lk_busy,
	output logic                    lk_done,
	output logic [127:0]            lk_rdata,
	output logic [RLEN_W-1:0]       lk_rlen,
	// Power stage conditions and pins
	input  wire logic [FLT_W-1:0]   fault_in,
	input  wire logic               remote_on,
	input  wire logic               power_good,
	input  wire logic               low_line,
	// Power stage control
	output logic                    out_enable,
	output logic                    vset_override,
	output logic [15:0]             vset_value,
	output logic                    nv_store,
	output logic [7:0]              nv_lock_value,
	// Alert line, open drain
	input  wire logic               smbalert_i,
	output logic                    smbalert_o,
	output logic                    smbalert_oe_n
);
	localparam int IN_W = FLT_W + 3;
	localparam logic [CNT_W-1:0] HOLD = CNT_W'(OFF_HOLD);

	logic                x_req_tog;
	logic                x_wr;
	logic [7:0]          x_cmd;
	logic [15:0]         x_wdata;

	typedef struct packed {
		logic [IN_W-1:0]   s1;
		logic [IN_W-1:0]   s2;
		logic              rq1;
		logic              rq2;
		logic              rq3;
		logic              ack_tog;
		logic [127:0]      rdata;
		logic [RLEN_W-1:0] rlen;
		logic [7:0]        on_cmd;
		logic [7:0]        lock;
		logic              vsw;
		logic [15:0]       vset;
		logic [7:0]        oc_rsp;
		logic [7:0]        ot_rsp;
		logic [FLT_W-1:0]  sts;
		logic              communication_fault_flag;
		logic              latched;
		logic [CNT_W-1:0]  off_cnt;
		logic              was_off;
		logic              out_en;
		logic              alert_n;
		logic              store;
	} psc_core_t;

	psc_core_t q_r;
	psc_core_t q_nxt;

	logic [FLT_W-1:0] live;
	logic             rmt;
	logic             pgood;
	logic             lowl;
	logic             req_new;
	logic             unit_off;
	logic             wr_ok;
	logic [7:0]       s_byte;
	logic [7:0]       s_hi;
	logic [7:0]       s_vout;
	logic [7:0]       s_iout;
	logic [7:0]       s_in;
	logic [7:0]       s_temp;
	logic [7:0]       s_vend;
	logic [7:0]       s_fan;

	psc_link u_link (
		.link_clk  (link_clk),
		.arst_n    (arst_n),
		.lk_req    (lk_req),
		.lk_wr     (lk_wr),
		.lk_cmd    (lk_cmd),
		.lk_wdata  (lk_wdata),
		.lk_busy   (lk_busy),
		.lk_done   (lk_done),
		.lk_rdata  (lk_rdata),
		.lk_rlen   (lk_rlen),
		.x_req_tog (x_req_tog),
		.x_wr      (x_wr),
		.x_cmd     (x_cmd),
		.x_wdata   (x_wdata),
		.x_ack_tog (q_r.ack_tog),
		.x_rdata   (q_r.rdata),
		.x_rlen    (q_r.rlen)
	);

	assign {live, rmt, pgood, lowl} = q_r.s2;
	assign req_new  = q_r.rq2 != q_r.rq3;
	assign unit_off = (q_r.on_cmd != OUT_ON) || !rmt;
	assign wr_ok    = (q_r.lock == LOCK_NONE) || (x_cmd == CMD_LOCK) ||
		((q_r.lock == LOCK_OPER) && (x_cmd == CMD_ON_OFF));

	// Category registers built from the sticky bits; vendor also takes the remote pin, low-line input and alert.
	assign s_vout = {q_r.sts[F_VOV_F], q_r.sts[F_VOV_W], q_r.sts[F_VUV_W],
		q_r.sts[F_VUV_F], 4'h0};
	assign s_iout = {q_r.sts[F_IOC_F], 1'b0, q_r.sts[F_IOC_W], 5'h00};
	assign s_in   = {q_r.sts[F_IOV_F], q_r.sts[F_IOV_W], q_r.sts[F_IUV_W],
		q_r.sts[F_IUV_F], 4'h0};
	assign s_temp = {q_r.sts[F_OT_F], q_r.sts[F_OT_W], 6'h00};
	assign s_fan  = {q_r.sts[F_FAN1_F], q_r.sts[F_FAN2_F], 2'h0,
		q_r.sts[F_FAN1_O], q_r.sts[F_FAN2_O], 2'h0};
	assign s_vend = {q_r.sts[F_RAIL_F], q_r.sts[F_VOV_F], !q_r.alert_n,
		(|q_r.sts), !rmt, q_r.sts[F_VOV_F] | q_r.sts[F_IOC_F],
		q_r.sts[F_IOV_F] | q_r.sts[F_IUV_F], lowl};
	assign s_hi   = {(|s_vout), (|s_iout), (|s_in), (|s_vend[7:1]),
		!(pgood && q_r.out_en), (|s_fan), q_r.sts[F_OTHER], 1'b0};
	assign s_byte[7:1] = {req_new, !q_r.out_en, q_r.sts[F_VOV_F],
		q_r.sts[F_IOC_F], q_r.sts[F_IUV_F], (|s_temp), q_r.communication_fault_flag};
	assign s_byte[0] = (|s_hi) && !(|s_byte[6:1]);

	always_comb begin
		q_nxt = q_r;
		q_nxt.s1 = {fault_in, remote_on, power_good, low_line};
		q_nxt.s2 = q_r.s1;
		q_nxt.rq1 = x_req_tog;
		q_nxt.rq2 = q_r.rq1;
		q_nxt.rq3 = q_r.rq2;
		q_nxt.store = 1'b0;
		q_nxt.sts = q_r.sts | live;
		if (unit_off) begin
			if (q_r.off_cnt != HOLD) begin
				q_nxt.off_cnt = q_r.off_cnt + 1'b1;
			end
		end else begin
			q_nxt.off_cnt = '0;
		end
		q_nxt.was_off = unit_off;
		// Leaving a long enough off period clears shutdowns and alarms.
		if (q_r.was_off && !unit_off && (q_r.off_cnt == HOLD)) begin
			q_nxt.latched = 1'b0;
			q_nxt.sts = live;
			q_nxt.communication_fault_flag = 1'b0;
		end
		if ((live[F_IOC_F] && (q_r.oc_rsp == RESP_LATCH)) ||
			(live[F_OT_F] && (q_r.ot_rsp == RESP_LATCH))) begin
			q_nxt.latched = 1'b1;
		end
		if (req_new) begin
			q_nxt.ack_tog = !q_r.ack_tog;
			q_nxt.rdata = '0;
			q_nxt.rlen = LEN_BYTE;
			unique case (x_cmd)
			CMD_ON_OFF: begin
				q_nxt.rdata[7:0] = q_r.on_cmd;
				if (x_wr && wr_ok && ((x_wdata[7:0] == OUT_ON) ||
					(x_wdata[7:0] == OUT_OFF))) begin
					q_nxt.on_cmd = x_wdata[7:0];
				end else if (x_wr) begin
					q_nxt.communication_fault_flag = 1'b1;
				end
			end
			CMD_CLEAR: begin
				q_nxt.rlen = LEN_NONE;
				q_nxt.sts = live;
				q_nxt.communication_fault_flag = 1'b0;
			end
			CMD_LOCK: begin
				q_nxt.rdata[7:0] = q_r.lock;
				if (x_wr && ((x_wdata[7:0] == LOCK_NONE) ||
					(x_wdata[7:0] == LOCK_ALL) ||
					(x_wdata[7:0] == LOCK_OPER))) begin
					q_nxt.lock = x_wdata[7:0];
				end else if (x_wr) begin
					q_nxt.communication_fault_flag = 1'b1;
				end
			end
			CMD_STORE: begin
				q_nxt.rlen = LEN_NONE;
				if (wr_ok) begin
					q_nxt.store = 1'b1;
				end else begin
					q_nxt.communication_fault_flag = 1'b1;
				end
			end
			CMD_VSET: begin
				q_nxt.rdata[15:0] = q_r.vset;
				q_nxt.rlen = LEN_WORD;
				if (x_wr && wr_ok) begin
					q_nxt.vset = x_wdata;
					q_nxt.vsw = 1'b1;
				end else if (x_wr) begin
					q_nxt.communication_fault_flag = 1'b1;
				end
			end
			CMD_OC_RESP, CMD_OT_RESP: begin
				q_nxt.rdata[7:0] = (x_cmd == CMD_OC_RESP) ? q_r.oc_rsp
					: q_r.ot_rsp;
				if (x_wr && wr_ok && ((x_wdata[7:0] == RESP_LATCH) ||
					(x_wdata[7:0] == RESP_HICCUP))) begin
					if (x_cmd == CMD_OC_RESP) begin
						q_nxt.oc_rsp = x_wdata[7:0];
					end else begin
						q_nxt.ot_rsp = x_wdata[7:0];
					end
				end else if (x_wr) begin
					q_nxt.communication_fault_flag = 1'b1;
				end
			end
			CMD_SBYTE:    q_nxt.rdata[7:0] = s_byte;
			CMD_SWORD: begin
				q_nxt.rdata[15:0] = {s_hi, s_byte};
				q_nxt.rlen = LEN_WORD;
			end
			CMD_S_VOUT:   q_nxt.rdata[7:0] = s_vout;
			CMD_S_IOUT:   q_nxt.rdata[7:0] = s_iout;
			CMD_S_INPUT:  q_nxt.rdata[7:0] = s_in;
			CMD_S_TEMP:   q_nxt.rdata[7:0] = s_temp;
			CMD_S_VENDOR: q_nxt.rdata[7:0] = s_vend;
			CMD_S_FAN:    q_nxt.rdata[7:0] = s_fan;
			CMD_MAKER: begin
				q_nxt.rdata[39:0] = MAKER_ID;
				q_nxt.rlen = LEN_MAKER;
			end
			CMD_MODEL: begin
				q_nxt.rdata = MODEL_ID;
				q_nxt.rlen = LEN_MODEL;
			end
			default: begin
				q_nxt.rlen = LEN_NONE;
				q_nxt.communication_fault_flag = 1'b1;
			end
			endcase
		end
		// Hiccup: output follows live faults; latch holds it off.
		q_nxt.out_en = !unit_off && !q_r.latched && !live[F_IOC_F] &&
			!live[F_OT_F] && !live[F_VOV_F];
		q_nxt.alert_n = !((|q_nxt.sts) || q_nxt.communication_fault_flag);
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			q_r <= '0;
			q_r.on_cmd <= OUT_ON;
			q_r.lock <= LOCK_ALL;
			q_r.vset <= VSET_RESET;
			q_r.vsw <= 1'b0;
			q_r.oc_rsp <= RESP_HICCUP;
			q_r.ot_rsp <= RESP_HICCUP;
			q_r.alert_n <= 1'b1;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign out_enable    = q_r.out_en;
	assign vset_override = q_r.vsw;
	assign vset_value    = q_r.vset;
	assign nv_store      = q_r.store;
	assign nv_lock_value = q_r.lock;
	assign smbalert_o    = 1'b0;
	assign smbalert_oe_n = q_r.alert_n;

	sequence s_off_wr;
		req_new && x_wr && (x_cmd == CMD_ON_OFF) && wr_ok &&
			(x_wdata[7:0] == OUT_OFF);
	endsequence
	sequence s_output_drops;
		(q_r.on_cmd == OUT_OFF) ##1 !q_r.out_en;
	endsequence

	AST_OFF_CMD: assert property (@(posedge clock) disable iff (!arst_n)
		s_off_wr |=> s_output_drops)
		else $error("Off command did not drop the output.");
	AST_LOCKED_VSET: assert property (@(posedge clock) disable iff (!arst_n)
		req_new && x_wr && (x_cmd == CMD_VSET) && (q_r.lock != LOCK_NONE)
		|=> $stable(q_r.vset) && (q_r.vsw == $past(q_r.vsw)))
		else $error("Blocked setpoint write changed state.");
	AST_CLEAR: assert property (@(posedge clock) disable iff (!arst_n)
		req_new && (x_cmd == CMD_CLEAR) |=> (q_r.sts == $past(live)) && !q_r.communication_fault_flag)
		else $error("Clear did not reduce status to live faults.");
	AST_REASSERT: assert property (@(posedge clock) disable iff (!arst_n)
		live[F_VOV_F] |=> q_r.sts[F_VOV_F] ##0 !q_r.alert_n)
		else $error("Present fault not flagged with alert.");
	AST_WORD: assert property (@(posedge clock) disable iff (!arst_n)
		req_new && !x_wr && (x_cmd == CMD_SWORD)
		|=> (q_r.rdata[7:0] == $past(s_byte)) && (q_r.rlen == LEN_WORD))
		else $error("Status word low byte differs from summary byte.");
	AST_READ_LOCK: assert property (@(posedge clock) disable iff (!arst_n)
		req_new && !x_wr && (x_cmd == CMD_LOCK)
		|=> (q_r.rdata[7:0] == $past(q_r.lock)) && (q_r.rlen == LEN_BYTE))
		else $error("Lock read refused or wrong.");
	AST_LATCH_OFF: assert property (@(posedge clock) disable iff (!arst_n)
		q_r.latched |=> !q_r.out_en)
		else $error("Latched unit drives its output.");
	AST_RESTART: assert property (@(posedge clock) disable iff (!arst_n)
		q_r.was_off && !unit_off && (q_r.off_cnt == HOLD) |=> !q_r.latched ||
		$past(live[F_IOC_F] || live[F_OT_F]))
		else $error("Long off period did not release the latch.");
	AST_FAN: assert property (@(posedge clock) disable iff (!arst_n)
		req_new && !x_wr && (x_cmd == CMD_S_FAN) |=>
		(q_r.rdata[7] == $past(q_r.sts[F_FAN1_F])) &&
		(q_r.rdata[2] == $past(q_r.sts[F_FAN2_O])))
		else $error("Fan status bit layout wrong.");
endmodule : psc_regs

// ==== bench/psc_host.sv ====
`timescale 1ns/100ps

module psc_host
	import psc_pkg::*;
(
	// Link request
	output logic                   link_clk,
	output logic                   lk_req,
	output logic                   lk_wr,
	output logic [7:0]             lk_cmd,
	output logic [15:0]            lk_wdata,
	// Link answer
	input  wire logic              lk_busy,
	input  wire logic              lk_done,
	input  wire logic [127:0]      lk_rdata,
	input  wire logic [RLEN_W-1:0] lk_rlen
);
	initial begin
		link_clk = 1'b0;
		lk_req   = 1'b0;
		lk_wr    = 1'b0;
		lk_cmd   = 8'h00;
		lk_wdata = 16'h0000;
	end

	task automatic tick();
		#62.5 link_clk = 1'b1;
		#62.5 link_clk = 1'b0;
	endtask : tick

	// The clock runs only inside a transfer; released command and data lines are inverted, the write line is held.
	task automatic xfer(
		input  logic              w,
		input  logic [7:0]        c,
		input  logic [15:0]       d,
		output logic [127:0]      rd,
		output logic [RLEN_W-1:0] rl,
		output logic              ok
	);
		logic seen;
		ok       = 1'b0;
		lk_wr    = w;
		lk_cmd   = c;
		lk_wdata = d;
		lk_req   = 1'b1;
		tick();
		seen     = lk_busy;
		lk_req   = 1'b0;
		lk_cmd   = ~c;
		lk_wdata = ~d;
		for (int n = 0; n < 40 && !ok; n++) begin
			tick();
			if (lk_done === 1'b1) begin
				rd = lk_rdata;
				rl = lk_rlen;
				ok = (seen === 1'b1);
			end
		end
		tick();
	endtask : xfer
endmodule : psc_host

// ==== bench/tb_top.sv ====
`timescale 1ns/100ps

module tb_top;
	import psc_pkg::*;
	// Identity values are arbitrary.
	localparam logic [39:0]  MID = 40'h515549585a;
	localparam logic [127:0] MOD = 128'h54455354554e49542d41424344454647;

	logic clock, arst_n, link_clk, lk_req, lk_wr, lk_busy, lk_done;
	logic [7:0] lk_cmd, nv_lock_value;
	logic [15:0] lk_wdata, vset_value, v;
	logic [127:0] lk_rdata, rd;
	logic [RLEN_W-1:0] lk_rlen, rl;
	logic [FLT_W-1:0] fault_in;
	logic remote_on, out_enable, vset_override, nv_store, ok, w;
	logic power_good, low_line;
	logic smbalert_i, smbalert_o, smbalert_oe_n;
	int fails, compares, stores, m_lock, m_on;
	// Fault index, register, bit, status word bit, summary byte bit.
	int tab[16][5] = '{
		'{F_VOV_F, 'h7a, 7, 15, 5}, '{F_VOV_W, 'h7a, 6, 15, -1},
		'{F_VUV_W, 'h7a, 5, 15, -1}, '{F_VUV_F, 'h7a, 4, 15, -1},
		'{F_IOC_F, 'h7b, 7, 14, 4}, '{F_IOC_W, 'h7b, 5, 14, -1},
		'{F_IOV_F, 'h7c, 7, 13, -1}, '{F_IOV_W, 'h7c, 6, 13, -1},
		'{F_IUV_W, 'h7c, 5, 13, -1}, '{F_IUV_F, 'h7c, 4, 13, 3},
		'{F_OT_F, 'h7d, 7, 2, 2}, '{F_OT_W, 'h7d, 6, 2, 2},
		'{F_FAN1_F, 'h81, 7, 10, -1}, '{F_FAN2_F, 'h81, 6, 10, -1},
		'{F_FAN1_O, 'h81, 3, 10, -1}, '{F_FAN2_O, 'h81, 2, 10, -1}};

	assign smbalert_i = smbalert_oe_n ? 1'b1 : smbalert_o;

	always #25 clock = ~clock;

	always @(posedge clock) begin
		if (nv_store === 1'b1)
			stores <= stores + 1;
	end

	psc_host host (.link_clk(link_clk), .lk_req(lk_req), .lk_wr(lk_wr),
		.lk_cmd(lk_cmd), .lk_wdata(lk_wdata), .lk_busy(lk_busy),
		.lk_done(lk_done), .lk_rdata(lk_rdata), .lk_rlen(lk_rlen));

	psc_regs #(.OFF_HOLD(20), .CNT_W(26), .MAKER_ID(MID), .MODEL_ID(MOD))
	uut (.clock(clock), .arst_n(arst_n), .link_clk(link_clk),
		.lk_req(lk_req), .lk_wr(lk_wr), .lk_cmd(lk_cmd),
		.lk_wdata(lk_wdata), .lk_busy(lk_busy), .lk_done(lk_done),
		.lk_rdata(lk_rdata), .lk_rlen(lk_rlen), .fault_in(fault_in),
		.remote_on(remote_on), .power_good(power_good),
		.low_line(low_line),
		.out_enable(out_enable), .vset_override(vset_override),
		.vset_value(vset_value), .nv_store(nv_store),
		.nv_lock_value(nv_lock_value), .smbalert_i(smbalert_i),
		.smbalert_o(smbalert_o), .smbalert_oe_n(smbalert_oe_n));

	task automatic complete_run();
		if (fails == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [127:0] got, exp, input string m);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk

	task automatic cw(input int n);
		repeat (n) @(negedge clock);
	endtask : cw

	task automatic tx(input logic wr, input logic [7:0] c,
		input logic [15:0] d);
		host.xfer(wr, c, d, rd, rl, ok);
		chk(ok, 1'b1, "no answer");
		cw(1);
	endtask : tx

	// Write through the lock model; only accepted writes move the model.
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		tx(1'b1, c, d);
		w = (c == CMD_LOCK) || (m_lock == 0) ||
			(m_lock == 'h40 && c == CMD_ON_OFF);
		if (w && c == CMD_LOCK && d[7:0] inside {8'h00, 8'h80, 8'h40})
			m_lock = d[7:0];
		if (w && c == CMD_ON_OFF)
			m_on = (d[7:0] == OUT_ON);
		cw(4);
	endtask : wr

	initial begin
		#2000000;
		fails++;
		complete_run();
	end

	initial begin
		clock = 1'b0;
		arst_n = 1'b0;
		fault_in = '0;
		remote_on = 1'b1;
		power_good = 1'b1;
		low_line = 1'b0;
		stores = 0;
		m_lock = 'h80;
		m_on = 1;
		void'($urandom(56405));
		cw(2);
		arst_n = 1'b1;
		cw(8);
		chk(out_enable, m_on, "power-up output");
		chk(nv_lock_value, 8'h80, "lock reset");
		tx(1'b0, CMD_LOCK, 16'h0000);
		chk(rd[7:0], 8'h80, "lock read");
		tx(1'b0, CMD_MAKER, 16'h0000);
		chk(rl, LEN_MAKER, "maker length");
		chk(rd[39:0], MID, "maker string");
		tx(1'b0, CMD_MODEL, 16'h0000);
		chk(rl, LEN_MODEL, "model length");
		chk(rd, MOD, "model string");
		wr(CMD_ON_OFF, OUT_OFF);
		chk(out_enable, m_on, "locked on/off");
		tx(1'b0, CMD_SBYTE, 16'h0000);
		chk(rd[1], 1'b1, "comm fault");
		chk(smbalert_oe_n, 1'b0, "alert set");
		tx(1'b1, CMD_CLEAR, 16'h0000);
		cw(4);
		chk(smbalert_oe_n, 1'b1, "alert release");
		wr(CMD_LOCK, LOCK_OPER);
		wr(CMD_VSET, 16'h1234);
		chk(vset_override, 1'b0, "locked setpoint");
		wr(CMD_ON_OFF, OUT_OFF);
		chk(out_enable, m_on, "off command");
		fault_in[F_OT_W] = 1'b1;
		cw(5);
		fault_in = '0;
		cw(30);
		wr(CMD_ON_OFF, OUT_ON);
		chk(out_enable, m_on, "on command");
		tx(1'b0, CMD_S_TEMP, 16'h0000);
		chk(rd[7:0], 8'h00, "restart clears");
		wr(CMD_LOCK, 16'h0033);
		tx(1'b0, CMD_LOCK, 16'h0000);
		chk(rd[7:0], m_lock, "bad lock value");
		wr(CMD_LOCK, LOCK_NONE);
		v = 16'($urandom);
		wr(CMD_VSET, v);
		chk(vset_override, 1'b1, "override");
		chk(vset_value, v, "setpoint");
		wr(CMD_STORE, 16'h0000);
		chk(stores, 1, "store pulse");
		tx(1'b0, CMD_OC_RESP, 16'h0000);
		chk(rd[7:0], RESP_HICCUP, "oc default");
		tx(1'b1, CMD_CLEAR, 16'h0000);
		for (int i = 0; i < 16; i++) begin
			fault_in[tab[i][0]] = 1'b1;
			cw(5 + $urandom_range(3));
			fault_in = '0;
			cw(5);
			tx(1'b0, 8'(tab[i][1]), 16'h0000);
			chk(rd[7:0], 8'h01 << tab[i][2], "category bit");
			tx(1'b0, CMD_SWORD, 16'h0000);
			chk(rd[tab[i][3]], 1'b1, "word bit");
			v = rd[15:0];
			tx(1'b0, CMD_SBYTE, 16'h0000);
			chk(rd[7:0], v[7:0], "word low byte");
			chk(rd[0], tab[i][4] < 0, "none of the above");
			if (tab[i][4] >= 0)
				chk(rd[tab[i][4]], 1'b1, "summary bit");
			tx(1'b1, CMD_CLEAR, 16'h0000);
			tx(1'b0, 8'(tab[i][1]), 16'h0000);
			chk(rd[7:0], 8'h00, "cleared");
		end
		fault_in[F_IUV_W] = 1'b1;
		cw(5);
		tx(1'b1, CMD_CLEAR, 16'h0000);
		cw(4);
		tx(1'b0, CMD_S_INPUT, 16'h0000);
		chk(rd[5], 1'b1, "persisting fault");
		chk(smbalert_oe_n, 1'b0, "alert again");
		fault_in = '0;
		cw(30);
		fault_in[F_IOC_F] = 1'b1;
		cw(5);
		chk(out_enable, 1'b0, "hiccup off");
		fault_in = '0;
		cw(30);
		chk(out_enable, 1'b1, "hiccup back on");
		wr(CMD_OC_RESP, RESP_LATCH);
		fault_in[F_IOC_F] = 1'b1;
		cw(5);
		fault_in = '0;
		cw(30);
		chk(out_enable, 1'b0, "latched off");
		remote_on = 1'b0;
		cw(30);
		remote_on = 1'b1;
		cw(8);
		chk(out_enable, 1'b1, "pin restart");
		tx(1'b0, CMD_S_IOUT, 16'h0000);
		chk(rd[7:0], 8'h00, "restart clears");
		power_good = 1'b0;
		low_line = 1'b1;
		cw(5);
		tx(1'b0, CMD_SWORD, 16'h0000);
		chk(rd[11], 1'b1, "power not good");
		tx(1'b0, CMD_S_VENDOR, 16'h0000);
		chk(rd[0], 1'b1, "low line");
		power_good = 1'b1;
		low_line = 1'b0;
		arst_n = 1'b0;
		cw(2);
		arst_n = 1'b1;
		cw(8);
		chk(vset_override, 1'b0, "pin sets voltage again");
		chk(nv_lock_value, 8'h80, "lock default again");
		chk(out_enable, 1'b1, "power-up output again");
		complete_run();
	end
endmodule : tb_top
